// ### bench/clkmc_pin_model.sv
// clkmc_pin_model: board side, four input clock sources and strapped configuration pins
`timescale 1ns/1ps
module clkmc_pin_model #(
    parameter int HALF = 8
) (
    // clock
    input wire logic hclk,
    // bench requests
    input wire logic [3:0] stop_in,
    input wire logic [1:0] tbl_req,
    input wire logic [1:0] bw_req,
    input wire logic [1:0] sel_req,
    input wire logic mode_req,
    // pins toward the device
    output logic [3:0] clock_input_n,
    output logic [1:0] freq_table_select,
    output logic [1:0] loop_bandwidth_select,
    output logic switch_mode_choice,
    output logic [1:0] input_select
);
    int ph;
    initial begin
        ph = 0;
        clock_input_n = 4'h0;
        freq_table_select = 2'h1;
        loop_bandwidth_select = 2'h0;
        switch_mode_choice = 1'b1;
        input_select = 2'h0;
    end
    // ==========================================================
    // sources
    // one shared rate, skewed a cycle apart; a stopped source sits low like a dead oscillator
    always @(posedge hclk) begin
        ph <= ph + 1;
        for (int k = 0; k < 4; k++)
            clock_input_n[k] <= !stop_in[k] && ((ph + k) / HALF) % 2 == 1;
        freq_table_select <= tbl_req; // code 11 stands for an open pin
        loop_bandwidth_select <= bw_req;
        switch_mode_choice <= mode_req;
        input_select <= sel_req;
    end
endmodule // clkmc_pin_model

// ### bench/clkmc_top_props.sv
// clkmc_top_props: concurrent checks on the ports of the clock multiplier control block
`timescale 1ns/1ps
module clkmc_props #(
    parameter int LOS_CYC = 64,
    parameter int CAL_CYC = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched ports
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic switch_mode_choice,
    input wire logic [1:0] input_select,
    input wire logic [3:0] clock_input_n,
    input wire logic [4:0] clock_output_n,
    input wire logic [4:0] clock_output_oe,
    input wire logic [3:0] input_invalid_flag,
    input wire logic frozen
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // helpers: cycles since each pin rose, cycles of steady manual selection
    logic [3:0] prev_r;
    logic [1:0] sel_r;
    int gap_r [4];
    int man_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 4'h0;
            sel_r <= 2'h0;
            man_r <= 0;
            gap_r <= '{default: 0};
        end else begin
            prev_r <= clock_input_n;
            sel_r <= input_select;
            man_r <= (switch_mode_choice && input_select == sel_r) ? man_r + 1 : 0;
            for (int k = 0; k < 4; k++)
                gap_r[k] <= (clock_input_n[k] && !prev_r[k]) ? 0 : gap_r[k] + 1;
        end
    end
    sequence calib_hold;
        (clock_output_oe == 5'h00) [*8];
    endsequence
    sequence lost_sel;
        man_r > 5 && input_invalid_flag[input_select] ##1 input_invalid_flag[input_select];
    endsequence
    sequence good_sel;
        man_r > 5 && !input_invalid_flag[input_select] ##1 !input_invalid_flag[input_select];
    endsequence
    // ==========================================================
    // assertions
    reset_state_a: assert property ($rose(hresetn) |-> input_invalid_flag == 4'h0 && !frozen && hrdata == 32'h0)
        else $error("state not cleared by reset");
    calib_hold_a: assert property ($rose(hresetn) |-> calib_hold)
        else $error("outputs enabled during calibration");
    hiz_low_a: assert property ((clock_output_n & ~clock_output_oe) == 5'h00)
        else $error("disabled output not low");
    freeze_on_loss_a: assert property (lost_sel |-> frozen)
        else $error("no freeze with selected input lost");
    resume_good_a: assert property (good_sel |-> !frozen)
        else $error("frozen with selected input good");
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    for (genvar i = 0; i < 4; i++) begin : g_in
        los_early_a: assert property ($rose(input_invalid_flag[i]) |-> gap_r[i] >= LOS_CYC)
            else $error("loss flag raised too early");
        los_raise_a: assert property (gap_r[i] == LOS_CYC + CAL_CYC + 8 |-> input_invalid_flag[i])
            else $error("loss flag not raised");
        flag_sticky_a: assert property ($fell(input_invalid_flag[i]) |-> gap_r[i] <= 6)
            else $error("loss flag dropped without input edges");
    end
endmodule // clkmc_props

bind clkmc_top clkmc_props #(.LOS_CYC(LOS_CYC), .CAL_CYC(CAL_CYC)) u_props (.hclk(hclk), .hresetn(hresetn),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .switch_mode_choice(switch_mode_choice),
    .input_select(input_select), .clock_input_n(clock_input_n), .clock_output_n(clock_output_n),
    .clock_output_oe(clock_output_oe), .input_invalid_flag(input_invalid_flag), .frozen(frozen));

// ### bench/clkmc_top_test.sv
// clkmc_top_test: self-checking bench for the clock multiplier control block
`timescale 1ns/1ps
module clkmc_top_test;
    localparam int LOS = 64;
    localparam int CAL = 8;
    typedef struct packed {logic [1:0] tbl; logic [1:0] bw; logic [1:0] sel; logic [5:0] exp;} clkmc_row_s;
    localparam clkmc_row_s ROWS [4] = '{'{2'h0, 2'h0, 2'h0, 6'h00}, '{2'h1, 2'h1, 2'h1, 6'h15},
        '{2'h2, 2'h2, 2'h2, 6'h2A}, '{2'h3, 2'h3, 2'h3, 6'h37}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, switch_mode_choice, frozen, cnt_clr, mode_req;
    logic [31:0] haddr, hwdata, hrdata, rd, per;
    logic [1:0] htrans, tbl_req, bw_req, sel_req, freq_table_select, loop_bandwidth_select, input_select;
    logic [3:0] stop_in, clock_input_n, input_invalid_flag;
    logic [4:0] clock_output_n, clock_output_oe;
    logic [8:0] mon, mon_r;
    int n_errors, total_checks;
    int rises [9];
    assign mon = {clock_input_n, clock_output_n};
    clkmc_pin_model #(.HALF(8)) u_pins (.hclk(hclk), .stop_in(stop_in), .tbl_req(tbl_req), .bw_req(bw_req),
        .sel_req(sel_req), .clock_input_n(clock_input_n), .freq_table_select(freq_table_select),
        .loop_bandwidth_select(loop_bandwidth_select), .switch_mode_choice(switch_mode_choice),
        .input_select(input_select), .mode_req(mode_req));
    clkmc_top #(.LOS_CYC(LOS), .CAL_CYC(CAL)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .freq_table_select(freq_table_select),
        .loop_bandwidth_select(loop_bandwidth_select), .switch_mode_choice(switch_mode_choice),
        .input_select(input_select), .clock_input_n(clock_input_n), .clock_output_n(clock_output_n),
        .clock_output_oe(clock_output_oe), .input_invalid_flag(input_invalid_flag), .frozen(frozen));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // rising edges of outputs [4:0] and inputs [8:5]
    always @(posedge hclk) begin
        mon_r <= mon;
        for (int k = 0; k < 9; k++)
            rises[k] <= cnt_clr ? 0 : rises[k] + int'(mon[k] & ~mon_r[k]);
    end
    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    function automatic logic [31:0] near(input int a, input int b);
        return 32'(a + 1 >= b && a <= b + 1 && b > 8);
    endfunction
    task automatic edge_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        #1;
        check(32'(clock_output_oe), 32'h0);
        check(32'(input_invalid_flag), 32'h0);
        cyc(20);
        hresetn <= 1'b1;
    endtask
    task automatic count(input int n);
        cnt_clr <= 1'b1;
        cyc(1);
        cnt_clr <= 1'b0;
        cyc(n);
    endtask
    task automatic wait_flag(input logic v);
        int k;
        for (k = 0; k < 300 && input_invalid_flag[2] !== v; k++)
            @(posedge hclk);
        if (k >= 300) begin
            n_errors++;
            complete_run();
        end
    endtask
    // ==========================================================
    // sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {bw_req, sel_req, stop_in} = '0;
        tbl_req = 2'h1;
        mode_req = 1'b1;
        cnt_clr = 1'b1;
        n_errors = 0;
        total_checks = 0;
        @(posedge hclk);
        do_reset();
        cyc(1);
        bus(1'b0, 32'h00, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 32'h04, 32'h0);
        check(rd, 32'h101);
        cyc(CAL);
        bus(1'b0, 32'h08, 32'h0);
        check(32'(rd[5]), 32'h1);
        check(32'(clock_output_oe), 32'h1F);
        $display("test reset done");
        foreach (ROWS[i]) begin
            tbl_req <= ROWS[i].tbl;
            bw_req <= ROWS[i].bw;
            sel_req <= ROWS[i].sel;
            cyc(8);
            bus(1'b0, 32'h08, 32'h0);
            check(32'(rd[11:6]), 32'(ROWS[i].exp));
        end
        $display("test pins done");
        tbl_req <= 2'h1;
        sel_req <= 2'h2;
        bus(1'b1, 32'h00, 32'h2);
        bus(1'b1, 32'h04, 32'h0402);
        bus(1'b0, 32'h04, 32'h0);
        check(rd, 32'h0402);
        bus(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        cyc(150);
        count(480);
        check(32'(clock_output_oe), 32'h1D);
        check(32'(rises[1]), 32'h0);
        check(32'(rises[2]), 32'(rises[0]));
        check(near(rises[3], rises[0] / 2), 32'h1);
        check(near(rises[4], rises[0] / 4), 32'h1);
        $display("test outputs done");
        bus(1'b1, 32'h00, 32'h100);
        cyc(10);
        count(480);
        check(near(rises[0], rises[7]), 32'h1);
        check(near(rises[3], rises[7]), 32'h1);
        bus(1'b1, 32'h00, 32'h0);
        $display("test bypass done");
        cyc(100);
        stop_in <= 4'h4;
        wait_flag(1'b1);
        check(32'(input_invalid_flag), 32'h4);
        cyc(2);
        check(32'(frozen), 32'h1);
        bus(1'b0, 32'h0C, 32'h0);
        per = rd;
        cyc(40);
        bus(1'b0, 32'h0C, 32'h0);
        check(rd, per);
        // automatic mode moves to the lowest input without alarm and leaves the freeze
        mode_req <= 1'b0;
        cyc(8);
        bus(1'b0, 32'h08, 32'h0);
        check(32'(rd[7:6]), 32'h0);
        check(32'(frozen), 32'h0);
        mode_req <= 1'b1;
        stop_in <= 4'h0;
        cyc(24);
        check(32'(input_invalid_flag), 32'h4);
        check(32'(frozen), 32'h1);
        wait_flag(1'b0);
        cyc(2);
        check(32'(frozen), 32'h0);
        $display("test loss done");
        do_reset();
        cyc(CAL + 6);
        check(32'(clock_output_oe), 32'h1F);
        $display("test midrun reset done");
        complete_run();
    end
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
endmodule // clkmc_top_test

// ### rtl/clkmc_pkg.sv
// clkmc_pkg: constants shared by the clock multiplier control block
package clkmc_pkg;
    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int LOS_TIME_NS = 750000;
    localparam int LOS_CYCLES = LOS_TIME_NS / CLK_PERIOD_NS;
    localparam int CAL_TIME_NS = 10000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VALID_EDGES = 4;
    localparam int NUM_IN = 4;
    localparam int NUM_OUT = 5;
    localparam int CNT_W = 18;

    // ======================================================================
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PERIOD = 8'h0C;

    // ctrl fields
    localparam int CTRL_PWDN_LSB = 0;
    localparam int CTRL_BYPASS_BIT = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // div fields: divider for output 3 in [7:0], output 4 in [15:8]
    localparam int DIV_A_LSB = 0;
    localparam int DIV_B_LSB = 8;
    localparam int DIV_W = 8;
    localparam logic [31:0] DIV_RESET = 32'h0000_0101;
    // status fields
    localparam int STAT_LOS_LSB = 0;
    localparam int STAT_FROZEN_BIT = 4;
    localparam int STAT_CAL_BIT = 5;
    localparam int STAT_SEL_LSB = 6;
    localparam int STAT_TBL_LSB = 8;
    localparam int STAT_BW_LSB = 10;

    // ======================================================================
    // three-level pin code as sampled: 00 low, 01 middle, 10 high, 11 floating
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    typedef enum logic [1:0] {CLKMC_TBL_SONET, CLKMC_TBL_DATACOM, CLKMC_TBL_XLATE} clkmc_tbl_e;
    typedef enum logic [1:0] {CLKMC_ST_CAL, CLKMC_ST_TRACK, CLKMC_ST_FROZEN} clkmc_state_e;

    // multiplication per table, as a right shift of the measured input period
    localparam int SHIFT_SONET = 2;
    localparam int SHIFT_DATACOM = 1;
    localparam int SHIFT_XLATE = 3;
endpackage

// ### rtl/clkmc_top.sv
// clkmc_top: pin-configured control around a frequency-multiplying clock synthesizer
`timescale 1ns/1ps
module clkmc_top #(
    parameter int LOS_CYC = clkmc_pkg::LOS_CYCLES,
    parameter int CAL_CYC = clkmc_pkg::CAL_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // configuration pins, asynchronous to hclk
    input wire logic [1:0] freq_table_select,
    input wire logic [1:0] loop_bandwidth_select,
    input wire logic switch_mode_choice,
    input wire logic [1:0] input_select,
    // clock inputs, sampled as levels
    input wire logic [3:0] clock_input_n,
    // clock outputs with enable, and alarms
    output logic [4:0] clock_output_n,
    output logic [4:0] clock_output_oe,
    output logic [3:0] input_invalid_flag,
    output logic frozen
);
    localparam int CW = clkmc_pkg::CNT_W;

    if (LOS_CYC < 2 || LOS_CYC >= (1 << CW) || CAL_CYC < 1 || CAL_CYC >= (1 << CW)) begin : g_chk
        $error("clkmc_top: count parameters out of range");
    end

    // ======================================================================
    // pin synchronisers
    logic [10:0] pin_s1_r;
    logic [10:0] pin_s2_r;
    logic [3:0] clk_prev_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            clk_prev_r <= '0;
        end else begin
            pin_s1_r <= {freq_table_select, loop_bandwidth_select, switch_mode_choice, input_select, clock_input_n};
            pin_s2_r <= pin_s1_r;
            clk_prev_r <= pin_s2_r[3:0];
        end
    end
    wire logic [3:0] clk_in = pin_s2_r[3:0];
    wire logic [1:0] sel_pin = pin_s2_r[5:4];
    wire logic manual_mode = pin_s2_r[6];
    wire logic [1:0] bw_pin = pin_s2_r[8:7];
    wire logic [1:0] tbl_pin = pin_s2_r[10:9];
    wire logic [3:0] clk_rise = clk_in & ~clk_prev_r;

    // ======================================================================
    // table decode
    function automatic clkmc_pkg::clkmc_tbl_e decode_table(input logic [1:0] lvl);
        if (lvl == clkmc_pkg::LVL_LOW) begin
            decode_table = clkmc_pkg::CLKMC_TBL_SONET;
        end else if (lvl == clkmc_pkg::LVL_HIGH) begin
            decode_table = clkmc_pkg::CLKMC_TBL_XLATE;
        end else begin
            // middle or floating both give datacom
            decode_table = clkmc_pkg::CLKMC_TBL_DATACOM;
        end
    endfunction

    function automatic logic [4:0] table_shift(input clkmc_pkg::clkmc_tbl_e t);
        case (t)
            clkmc_pkg::CLKMC_TBL_SONET: table_shift = 5'(clkmc_pkg::SHIFT_SONET);
            clkmc_pkg::CLKMC_TBL_XLATE: table_shift = 5'(clkmc_pkg::SHIFT_XLATE);
            default: table_shift = 5'(clkmc_pkg::SHIFT_DATACOM);
        endcase
    endfunction

    clkmc_pkg::clkmc_tbl_e table_now;
    assign table_now = decode_table(tbl_pin);

    // ======================================================================
    // loss-of-signal monitors, one per input
    logic [CW-1:0] gap_cnt_r [clkmc_pkg::NUM_IN];
    logic [2:0] good_cnt_r [clkmc_pkg::NUM_IN];
    logic [3:0] los_r;
    for (genvar i = 0; i < clkmc_pkg::NUM_IN; i++) begin : g_los
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                gap_cnt_r[i] <= '0;
                good_cnt_r[i] <= '0;
                los_r[i] <= 1'b0;
            end else if (clk_rise[i]) begin
                gap_cnt_r[i] <= '0;
                // alarm holds until enough regular edges validate the input
                if (los_r[i] && good_cnt_r[i] == 3'(clkmc_pkg::VALID_EDGES - 1)) begin
                    los_r[i] <= 1'b0;
                    good_cnt_r[i] <= '0;
                end else if (los_r[i]) begin
                    good_cnt_r[i] <= good_cnt_r[i] + 3'h1;
                end
            end else if (gap_cnt_r[i] == CW'(LOS_CYC - 1)) begin
                los_r[i] <= 1'b1;
                good_cnt_r[i] <= '0;
            end else begin
                gap_cnt_r[i] <= gap_cnt_r[i] + CW'(1);
            end
        end
    end
    assign input_invalid_flag = los_r;

    // ======================================================================
    // input selection: manual pins, or the first input without alarm
    logic [1:0] auto_sel;
    always_comb begin
        auto_sel = 2'h0;
        for (int k = clkmc_pkg::NUM_IN - 1; k >= 0; k--) begin
            if (!los_r[k]) begin
                auto_sel = 2'(k);
            end
        end
    end
    logic [1:0] act_sel_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_sel_r <= 2'h0;
        end else begin
            act_sel_r <= manual_mode ? sel_pin : auto_sel;
        end
    end
    wire logic sel_clk = clk_in[act_sel_r];
    wire logic sel_rise = clk_rise[act_sel_r];
    wire logic sel_los = los_r[act_sel_r];

    // ======================================================================
    // calibration, tracking and freeze
    clkmc_pkg::clkmc_state_e state_r;
    logic [CW-1:0] cal_cnt_r;
    logic [CW-1:0] meas_cnt_r;
    logic [CW-1:0] nco_half_r;
    logic [CW:0] diff;
    logic [CW-1:0] target;
    // every input shares one rate, so only the selected one is measured
    assign target = (meas_cnt_r >> (table_shift(table_now) + 5'h1)) | CW'(1);
    assign diff = {1'b0, target} - {1'b0, nco_half_r};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= clkmc_pkg::CLKMC_ST_CAL;
            cal_cnt_r <= '0;
        end else begin
            case (state_r)
                clkmc_pkg::CLKMC_ST_CAL: begin
                    if (cal_cnt_r == CW'(CAL_CYC - 1)) begin
                        state_r <= clkmc_pkg::CLKMC_ST_TRACK;
                    end else begin
                        cal_cnt_r <= cal_cnt_r + CW'(1);
                    end
                end
                clkmc_pkg::CLKMC_ST_TRACK: begin
                    if (sel_los) begin
                        state_r <= clkmc_pkg::CLKMC_ST_FROZEN;
                    end
                end
                default: begin
                    if (!sel_los) begin
                        state_r <= clkmc_pkg::CLKMC_ST_TRACK;
                    end
                end
            endcase
        end
    end
    assign frozen = (state_r == clkmc_pkg::CLKMC_ST_FROZEN);

    // period of the selected input in hclk cycles
    logic [CW-1:0] per_cnt_r;
    logic meas_new_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_cnt_r <= '0;
            meas_cnt_r <= '0;
            meas_new_r <= 1'b0;
        end else begin
            meas_new_r <= sel_rise;
            if (sel_rise) begin
                meas_cnt_r <= per_cnt_r;
                per_cnt_r <= CW'(1);
            end else if (per_cnt_r != '1) begin
                per_cnt_r <= per_cnt_r + CW'(1);
            end
        end
    end

    // loop update: bandwidth code sets the step, a wider code a faster loop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nco_half_r <= CW'(1);
        end else if (state_r == clkmc_pkg::CLKMC_ST_TRACK && meas_new_r && !sel_los) begin
            nco_half_r <= nco_half_r + CW'($signed(diff) >>> (3'h4 - {1'b0, bw_pin}));
        end
        // frozen: the half period simply holds its last value
    end

    // ======================================================================
    // synthesizer stand-in and output dividers
    logic [CW-1:0] nco_cnt_r;
    logic synth_r;
    logic synth_tgl;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nco_cnt_r <= '0;
            synth_r <= 1'b0;
        end else if (nco_cnt_r >= nco_half_r - CW'(1)) begin
            nco_cnt_r <= '0;
            synth_r <= ~synth_r;
        end else begin
            nco_cnt_r <= nco_cnt_r + CW'(1);
        end
    end
    assign synth_tgl = (nco_cnt_r >= nco_half_r - CW'(1));

    logic [31:0] ctrl_r;
    logic [31:0] div_r;
    logic [clkmc_pkg::DIV_W-1:0] dcnt_r [2];
    logic [1:0] sub_r;
    for (genvar j = 0; j < 2; j++) begin : g_div
        wire logic [clkmc_pkg::DIV_W-1:0] n = j == 0 ?
            div_r[clkmc_pkg::DIV_A_LSB +: clkmc_pkg::DIV_W] : div_r[clkmc_pkg::DIV_B_LSB +: clkmc_pkg::DIV_W];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                dcnt_r[j] <= '0;
                sub_r[j] <= 1'b0;
            end else if (synth_tgl) begin
                // a divisor of 0 or 1 passes the common rate
                if (dcnt_r[j] + 8'h1 >= n) begin
                    dcnt_r[j] <= '0;
                    sub_r[j] <= ~sub_r[j];
                end else begin
                    dcnt_r[j] <= dcnt_r[j] + 8'h1;
                end
            end
        end
    end

    wire logic bypass = ctrl_r[clkmc_pkg::CTRL_BYPASS_BIT];
    wire logic [4:0] pwdn = ctrl_r[clkmc_pkg::CTRL_PWDN_LSB +: clkmc_pkg::NUM_OUT];
    wire logic run = (state_r != clkmc_pkg::CLKMC_ST_CAL);
    // a closed enable also holds its data low, so nothing toggles behind a disabled pad
    wire logic [4:0] out_en = {5{run}} & ~pwdn;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_output_n <= '0;
            clock_output_oe <= '0;
        end else begin
            if (bypass) begin
                clock_output_n <= {5{sel_clk}} & out_en;
            end else begin
                clock_output_n <= {sub_r, {3{synth_r}}} & out_en;
            end
            clock_output_oe <= out_en;
        end
    end

    // ======================================================================
    // ahb-lite slave, zero wait states, always okay
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    wire logic take = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= clkmc_pkg::CTRL_RESET;
            div_r <= clkmc_pkg::DIV_RESET;
        end else if (wr_pend_r) begin
            if (wr_addr_r == clkmc_pkg::REG_CTRL) begin
                ctrl_r <= hwdata & 32'h0000_011F;
            end else if (wr_addr_r == clkmc_pkg::REG_DIV) begin
                div_r <= hwdata & 32'h0000_FFFF;
            end
        end
    end

    logic [31:0] status;
    always_comb begin
        status = '0;
        status[clkmc_pkg::STAT_LOS_LSB +: 4] = los_r;
        status[clkmc_pkg::STAT_FROZEN_BIT] = frozen;
        status[clkmc_pkg::STAT_CAL_BIT] = run;
        status[clkmc_pkg::STAT_SEL_LSB +: 2] = act_sel_r;
        status[clkmc_pkg::STAT_TBL_LSB +: 2] = table_now;
        status[clkmc_pkg::STAT_BW_LSB +: 2] = bw_pin;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            if (haddr[7:0] == clkmc_pkg::REG_CTRL && haddr[31:8] == '0) begin
                hrdata <= ctrl_r;
            end else if (haddr[7:0] == clkmc_pkg::REG_DIV && haddr[31:8] == '0) begin
                hrdata <= div_r;
            end else if (haddr[7:0] == clkmc_pkg::REG_STATUS && haddr[31:8] == '0) begin
                hrdata <= status;
            end else if (haddr[7:0] == clkmc_pkg::REG_PERIOD && haddr[31:8] == '0) begin
                hrdata <= {{(32 - CW){1'b0}}, nco_half_r};
            end else begin
                hrdata <= '0;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule // clkmc_top
